// [shared/tapcfg_regs.vh]
`ifndef TAPCFG_REGS_VH
`define TAPCFG_REGS_VH
// register offsets (8-bit address space)
`define TAPCFG_OFS_CFG0        8'h56
`define TAPCFG_OFS_CFG1        8'h57
`define TAPCFG_OFS_CFG2        8'h58
`define TAPCFG_OFS_THSZ        8'h59
`define TAPCFG_OFS_STATUS      8'h60
`define TAPCFG_OFS_MASK        8'h61
// cfg0 field positions
`define TAPCFG_CLR_ON_READ_BIT 6
`define TAPCFG_SLEEP_STAT_BIT  5
`define TAPCFG_FILTER_BIT      4
`define TAPCFG_TAP_X_EN_BIT    3
`define TAPCFG_TAP_Y_EN_BIT    2
`define TAPCFG_TAP_Z_EN_BIT    1
`define TAPCFG_LATCH_BIT       0
// cfg1 / cfg2 field positions
`define TAPCFG_PRIO_LSB        5
`define TAPCFG_INT_EN_BIT      7
`define TAPCFG_INACT_LSB       5
// reset values
`define TAPCFG_CFG_RESET       8'h00
`define TAPCFG_MASK_RESET      8'h00
// inactivity power modes
`define TAPCFG_INACT_NONE      2'b00
`define TAPCFG_INACT_XL_LP     2'b01
`define TAPCFG_INACT_GY_SLEEP  2'b10
`define TAPCFG_INACT_GY_OFF    2'b11
// event indices in the status register
`define TAPCFG_EV_ORIENT       0
`define TAPCFG_EV_FREEFALL     1
`define TAPCFG_EV_WAKE         2
`define TAPCFG_EV_TAP          3
`define TAPCFG_EV_INACT        4
`define TAPCFG_EV_SLEEP        5
`define TAPCFG_NUM_EVENTS      6
`endif

// [core/tapcfg_core.v]
// Function
// - clear-on-read set: status read clears latch; else clear at end of data period.
// - sleep route on: pin shows sleep status if selector 1, else change pulse.
// - filter select 0 feeds slope data, 1 feeds high-pass data; resets 0.
// - each axis joins tap recognition only when its enable is 1; reset 0.
// - latch enable 1 holds requests until cleared; 0 (reset) does not latch.
// - three-bit priority code decodes to max, mid, min axis order.
// - separate five-bit x and y tap thresholds, reset 0, step full scale/32.
// - basic interrupts generated only while global enable is 1; reset 0.
// - inactivity mode sets accelerometer 12.5 Hz and gyro unchanged, sleep or off.
// - separate five-bit z tap threshold, reset 0, step full scale/32.
//
// Chosen here: the address-and-strobe port.
`include "tapcfg_regs.vh"
`default_nettype none

module tapcfg_core #(
  parameter NEV = `TAPCFG_NUM_EVENTS        // number of event sources
) (
  input  wire            clock,             // 125 MHz system clock
  input  wire            reset,             // synchronous, active high
  input  wire [7:0]      reg_addr,          // register address
  input  wire [7:0]      reg_wdata,         // write data
  input  wire            reg_write,         // write strobe
  input  wire            reg_read,          // read strobe
  output reg  [7:0]      reg_rdata,         // read data, cycle after strobe
  input  wire            odr_tick,          // end of output data period pulse
  input  wire [4:0]      event_raw,         // orient,freefall,wake,tap,inact conditions
  input  wire            sleep_state,       // current sleep status
  input  wire [15:0]     accel_slope,       // slope-filtered acceleration
  input  wire [15:0]     accel_highpass,    // high-pass filtered acceleration
  input  wire            pin1_sleep_change_route, // sleep route to pin 1
  input  wire            pin2_sleep_change_route, // sleep route to pin 2
  output reg  [15:0]     wake_filter_data,  // data to wake-up/activity logic
  output reg  [2:0]      tap_axis_enable,   // x,y,z tap enables
  output reg  [8:0]      tap_axis_order,    // max,mid,min axis codes, 3-bit one-hot each
  output reg  [4:0]      tap_threshold_axis_x, // x tap threshold
  output reg  [4:0]      tap_threshold_axis_y, // y tap threshold
  output reg  [4:0]      tap_threshold_axis_z, // z tap threshold
  output reg             accel_low_power,   // accelerometer forced to 12.5 Hz
  output reg             gyro_sleep,        // gyroscope to sleep
  output reg             gyro_power_down,   // gyroscope powered down
  output reg             event_int1,        // event interrupt pin 1
  output reg             event_int2,        // event interrupt pin 2
  output reg             irq                // status/mask interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // axis codes and priority decoding
  localparam [2:0] AX_X = 3'b001;
  localparam [2:0] AX_Y = 3'b010;
  localparam [2:0] AX_Z = 3'b100;

  // decode priority code to {max,mid,min} one-hot axes
  function [8:0] prio_decode;
    input [2:0] code;
    begin
      case (code)
        3'b000:  prio_decode = {AX_X, AX_Y, AX_Z};
        3'b001:  prio_decode = {AX_Y, AX_X, AX_Z};
        3'b010:  prio_decode = {AX_X, AX_Z, AX_Y};
        3'b011:  prio_decode = {AX_Z, AX_Y, AX_X};
        3'b100:  prio_decode = {AX_X, AX_Y, AX_Z};
        3'b101:  prio_decode = {AX_Y, AX_Z, AX_X};
        3'b110:  prio_decode = {AX_Z, AX_X, AX_Y};
        default: prio_decode = {AX_Z, AX_Y, AX_X};
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register map, all registers eight bits wide
  //   0x56  bit 6 clear latch on status read
  //         bit 5 sleep status (1) or sleep change (0) on the pins
  //         bit 4 wake filter select, 0 slope, 1 high-pass
  //         bits 3..1 tap enables for x, y, z
  //         bit 0 interrupt latch enable
  //         bit 7 is not implemented and reads 0
  //   0x57  bits 7..5 tap axis priority, bits 4..0 x tap threshold
  //   0x58  bit 7 basic interrupt enable, bits 6..5 inactivity mode,
  //         bits 4..0 y tap threshold
  //   0x59  bits 4..0 z tap threshold, upper bits stored but unused here
  //   0x60  sticky status, bits 4..0 events, bit 5 sleep change,
  //         cleared by reading it
  //   0x61  irq mask, same layout as the status register
  // unmapped addresses read 0 and ignore writes
  // one threshold step is full scale / 32 on every axis
  localparam [5:0] SEL_CFG0   = 6'h01;
  localparam [5:0] SEL_CFG1   = 6'h02;
  localparam [5:0] SEL_CFG2   = 6'h04;
  localparam [5:0] SEL_THSZ   = 6'h08;
  localparam [5:0] SEL_STATUS = 6'h10;
  localparam [5:0] SEL_MASK   = 6'h20;

  // address decode shared by the write and read paths
  function [5:0] addr_decode;
    input [7:0] addr;
    begin
      if (addr == `TAPCFG_OFS_CFG0) begin
        addr_decode = SEL_CFG0;
      end else if (addr == `TAPCFG_OFS_CFG1) begin
        addr_decode = SEL_CFG1;
      end else if (addr == `TAPCFG_OFS_CFG2) begin
        addr_decode = SEL_CFG2;
      end else if (addr == `TAPCFG_OFS_THSZ) begin
        addr_decode = SEL_THSZ;
      end else if (addr == `TAPCFG_OFS_STATUS) begin
        addr_decode = SEL_STATUS;
      end else if (addr == `TAPCFG_OFS_MASK) begin
        addr_decode = SEL_MASK;
      end else begin
        addr_decode = 6'h00;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  reg [7:0] cfg0_reg;
  reg [7:0] cfg1_reg;
  reg [7:0] cfg2_reg;
  reg [7:0] thsz_reg;
  reg [7:0] mask_reg;
  reg [7:0] status_reg;

  wire clear_latch_on_status_read = cfg0_reg[`TAPCFG_CLR_ON_READ_BIT];
  wire sleep_status_select        = cfg0_reg[`TAPCFG_SLEEP_STAT_BIT];
  wire wake_filter_select         = cfg0_reg[`TAPCFG_FILTER_BIT];
  wire interrupt_latch_enable     = cfg0_reg[`TAPCFG_LATCH_BIT];
  wire basic_int_enable           = cfg2_reg[`TAPCFG_INT_EN_BIT];
  wire [1:0] inactivity_power_mode = cfg2_reg[`TAPCFG_INACT_LSB+1:`TAPCFG_INACT_LSB];

  // one select line per register, shared by writes and reads
  wire [5:0] addr_sel = addr_decode(reg_addr);
  wire wr_cfg0   = reg_write && addr_sel[0];
  wire wr_cfg1   = reg_write && addr_sel[1];
  wire wr_cfg2   = reg_write && addr_sel[2];
  wire wr_thsz   = reg_write && addr_sel[3];
  wire wr_mask   = reg_write && addr_sel[5];
  wire rd_status = reg_read && addr_sel[4];

  // register writes; bit 7 of cfg0 reads as zero
  always @(posedge clock) begin
    if (reset) begin
      cfg0_reg <= `TAPCFG_CFG_RESET;
      cfg1_reg <= `TAPCFG_CFG_RESET;
      cfg2_reg <= `TAPCFG_CFG_RESET;
      thsz_reg <= `TAPCFG_CFG_RESET;
      mask_reg <= `TAPCFG_MASK_RESET;
    end else begin
      if (wr_cfg0) begin
        cfg0_reg <= {1'b0, reg_wdata[6:0]};
      end
      if (wr_cfg1) begin
        cfg1_reg <= reg_wdata;
      end
      if (wr_cfg2) begin
        cfg2_reg <= reg_wdata;
      end
      if (wr_thsz) begin
        thsz_reg <= reg_wdata;
      end
      if (wr_mask) begin
        mask_reg <= {2'b00, reg_wdata[5:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event latching
  reg        sleep_prev_reg;
  reg  [4:0] latch_reg;
  wire       sleep_change = sleep_state ^ sleep_prev_reg;
  wire [4:0] event_gated  = basic_int_enable ? event_raw : 5'h00;
  wire [4:0] event_level;

  // latch behaviour per event bit:
  //   latch off    : nothing is held, the pin follows the gated condition
  //   latch on     : a gated condition sets the bit until a clear
  //   clear source : status read when clear-on-read is set, else the
  //                  end-of-period tick
  //   a new condition in the clearing cycle keeps the bit set
  // software has to set latch enable along with clear-on-read; with
  // clear-on-read alone nothing is latched, so nothing needs clearing
  // each event latches when enabled, else follows its condition
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_latch
      always @(posedge clock) begin
        if (reset) begin
          latch_reg[gi] <= 1'b0;
        end else if (!interrupt_latch_enable) begin
          latch_reg[gi] <= 1'b0;
        end else if (event_gated[gi]) begin
          latch_reg[gi] <= 1'b1;
        end else if (clear_latch_on_status_read && rd_status) begin
          latch_reg[gi] <= 1'b0;
        end else if (!clear_latch_on_status_read && odr_tick) begin
          latch_reg[gi] <= 1'b0;
        end
      end
      assign event_level[gi] = event_gated[gi] | latch_reg[gi];
    end
  endgenerate

  // sleep history for change detection
  always @(posedge clock) begin
    if (reset) begin
      sleep_prev_reg <= 1'b0;
    end else begin
      sleep_prev_reg <= sleep_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive and functional outputs
  wire sleep_pin_val = sleep_status_select ? sleep_state : sleep_change;
  wire any_event     = |event_level;

  // every output here is registered, one cycle behind the settings it
  // follows, so a register write shows on the outputs two cycles later

  // interrupt pins: event level or routed sleep indication
  always @(posedge clock) begin
    if (reset) begin
      event_int1 <= 1'b0;
      event_int2 <= 1'b0;
    end else begin
      event_int1 <= any_event | (pin1_sleep_change_route & sleep_pin_val);
      event_int2 <= any_event | (pin2_sleep_change_route & sleep_pin_val);
    end
  end

  // data source for the wake-up and activity functions
  always @(posedge clock) begin
    if (reset) begin
      wake_filter_data <= 16'h0000;
    end else begin
      wake_filter_data <= wake_filter_select ? accel_highpass : accel_slope;
    end
  end

  // tap axis enables, priority order and thresholds
  always @(posedge clock) begin
    if (reset) begin
      tap_axis_enable      <= 3'b000;
      tap_axis_order       <= 9'h000;
      tap_threshold_axis_x <= 5'h00;
      tap_threshold_axis_y <= 5'h00;
      tap_threshold_axis_z <= 5'h00;
    end else begin
      tap_axis_enable <= {cfg0_reg[`TAPCFG_TAP_X_EN_BIT], cfg0_reg[`TAPCFG_TAP_Y_EN_BIT],
                          cfg0_reg[`TAPCFG_TAP_Z_EN_BIT]};
      tap_axis_order <= prio_decode(cfg1_reg[`TAPCFG_PRIO_LSB+2:`TAPCFG_PRIO_LSB]);
      tap_threshold_axis_x <= cfg1_reg[4:0];
      tap_threshold_axis_y <= cfg2_reg[4:0];
      tap_threshold_axis_z <= thsz_reg[4:0];
    end
  end

  // inactivity mode decode to power requests
  always @(posedge clock) begin
    if (reset) begin
      accel_low_power <= 1'b0;
      gyro_sleep      <= 1'b0;
      gyro_power_down <= 1'b0;
    end else begin
      accel_low_power <= (inactivity_power_mode != `TAPCFG_INACT_NONE);
      gyro_sleep      <= (inactivity_power_mode == `TAPCFG_INACT_GY_SLEEP);
      gyro_power_down <= (inactivity_power_mode == `TAPCFG_INACT_GY_OFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, read-clear, mask and irq
  //   bits 4..0 follow the gated event conditions, bit 5 the sleep change
  //   a set in the same cycle as the read clear wins, so an event that
  //   arrives while software reads the register is not lost
  localparam NST = NEV;  // status bits in use
  wire [NST-1:0] status_set = {sleep_change, event_gated};
  reg  [NST-1:0] status_keep;
  reg  [NST-1:0] status_next;
  reg            irq_next;

  // status bits survive unless the status register is read
  always @* begin
    if (rd_status) begin
      status_keep = {NST{1'b0}};
    end else begin
      status_keep = status_reg[NST-1:0];
    end
  end

  // set wins over the read clear; irq looks at the next status value
  always @* begin
    status_next = status_set | status_keep;
    irq_next    = |(status_next & mask_reg[NST-1:0]);
  end

  // status and irq flip-flops
  always @(posedge clock) begin
    if (reset) begin
      status_reg <= 8'h00;
      irq        <= 1'b0;
    end else begin
      status_reg <= {{(8-NST){1'b0}}, status_next};
      irq        <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data
  always @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (addr_sel[0]) begin
        reg_rdata <= cfg0_reg;
      end else if (addr_sel[1]) begin
        reg_rdata <= cfg1_reg;
      end else if (addr_sel[2]) begin
        reg_rdata <= cfg2_reg;
      end else if (addr_sel[3]) begin
        reg_rdata <= thsz_reg;
      end else if (addr_sel[4]) begin
        reg_rdata <= status_reg;
      end else if (addr_sel[5]) begin
        reg_rdata <= mask_reg;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// [testbench/tapcfg_checker.sv]
`include "tapcfg_regs.vh"
`default_nettype none
module tapcfg_checker (
  input wire logic        clock,                   // clock
  input wire logic        reset,                   // sync reset
  input wire logic [7:0]  reg_addr,                // address
  input wire logic [7:0]  reg_wdata,               // write data
  input wire logic        reg_write,               // write strobe
  input wire logic        reg_read,                // read strobe
  input wire logic        odr_tick,                // period end
  input wire logic [4:0]  event_raw,               // conditions
  input wire logic        sleep_state,             // sleep level
  input wire logic [15:0] accel_slope,             // slope data
  input wire logic [15:0] accel_highpass,          // high-pass data
  input wire logic        pin1_sleep_change_route, // sleep route
  input wire logic [15:0] wake_filter_data,        // filter out
  input wire logic [2:0]  tap_axis_enable,         // axis enables
  input wire logic [8:0]  tap_axis_order,          // axis order
  input wire logic [4:0]  tap_threshold_axis_x,    // x threshold
  input wire logic [4:0]  tap_threshold_axis_y,    // y threshold
  input wire logic [4:0]  tap_threshold_axis_z,    // z threshold
  input wire logic        accel_low_power,         // accel slow
  input wire logic        gyro_sleep,              // gyro sleep
  input wire logic        gyro_power_down,         // gyro off
  input wire logic        event_int1,              // pin 1
  input wire logic        irq                      // masked status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cfg0_reg, cfg1_reg, cfg2_reg, thsz_reg, mask_reg;
  wire        rd_status = reg_read && reg_addr == `TAPCFG_OFS_STATUS;
  wire  [1:0] mode = cfg2_reg[6:5];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  // shadow copy of the written configuration
  always_ff @(posedge clock) begin
    if (reset) begin
      {cfg0_reg, cfg1_reg, cfg2_reg, thsz_reg, mask_reg} <= 40'h00_0000_0000;
    end else if (reg_write) begin
      case (reg_addr)
        `TAPCFG_OFS_CFG0: cfg0_reg <= reg_wdata;
        `TAPCFG_OFS_CFG1: cfg1_reg <= reg_wdata;
        `TAPCFG_OFS_CFG2: cfg2_reg <= reg_wdata;
        `TAPCFG_OFS_THSZ: thsz_reg <= reg_wdata;
        `TAPCFG_OFS_MASK: mask_reg <= reg_wdata;
        default: ;
      endcase
    end
  end
  // axis order per priority code, one-hot x=001 y=010 z=100
  function automatic logic [8:0] prio(input logic [2:0] c);
    case (c)
      3'd1: prio = 9'b010_001_100;
      3'd2: prio = 9'b001_100_010;
      3'd3, 3'd7: prio = 9'b100_010_001;
      3'd5: prio = 9'b010_100_001;
      3'd6: prio = 9'b100_001_010;
      default: prio = 9'b001_010_100;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////
  a_filter_sel: assert property (!$past(reset) |-> wake_filter_data ==
    ($past(cfg0_reg[4]) ? $past(accel_highpass) : $past(accel_slope))) else $error("filter");
  a_tap_enable: assert property (!$past(reset) |->
    tap_axis_enable == $past(cfg0_reg[3:1])) else $error("tap enables");
  a_thresholds: assert property (!$past(reset) |->
    {tap_threshold_axis_x, tap_threshold_axis_y, tap_threshold_axis_z} ==
    {$past(cfg1_reg[4:0]), $past(cfg2_reg[4:0]), $past(thsz_reg[4:0])}) else $error("thresh");
  a_prio_decode: assert property (!$past(reset) |->
    tap_axis_order == prio($past(cfg1_reg[7:5]))) else $error("priority");
  a_power_mode: assert property (!$past(reset) |->
    {accel_low_power, gyro_sleep, gyro_power_down} ==
    {$past(mode) != 2'b00, $past(mode) == 2'b10, $past(mode) == 2'b11}) else $error("power");
  a_irq_masked: assert property ($past(mask_reg) == 8'h00 |-> !irq) else $error("irq");
  a_unlatched_follow: assert property (!$past(reset) && !$past(cfg0_reg[0]) &&
    !$past(cfg0_reg[0], 2) && !$past(pin1_sleep_change_route) |->
    event_int1 == ($past(cfg2_reg[7]) && |$past(event_raw))) else $error("unlatched");
  a_sleep_status: assert property (!$past(reset) && $past(pin1_sleep_change_route) &&
    $past(cfg0_reg[5]) && !$past(cfg2_reg[7]) && !$past(cfg0_reg[0]) && !$past(cfg0_reg[0], 2) |->
    event_int1 == $past(sleep_state)) else $error("sleep status");
  a_hold_latch: assert property ($past(event_int1) && $past(cfg0_reg[6], 2) &&
    $past(cfg0_reg[0], 2) && !$past(rd_status, 2) && !$past(reset) && !$past(reset, 2) &&
    !$past(pin1_sleep_change_route, 2) |-> event_int1) else $error("latch hold");
  a_tick_clear: assert property ($past(odr_tick) && $past(cfg0_reg[0]) &&
    !$past(cfg0_reg[6]) && $past(event_raw) == 5'h00 && !$past(pin1_sleep_change_route)
    |-> ##[0:2] !event_int1) else $error("tick clear");
  cover property (event_int1 && irq);
  cover property (gyro_power_down);
  cover property (tap_axis_order == 9'b100_001_010);
endmodule
bind tapcfg_core tapcfg_checker i_chk (.clock, .reset, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .odr_tick, .event_raw, .sleep_state, .accel_slope, .accel_highpass,
  .pin1_sleep_change_route, .wake_filter_data, .tap_axis_enable, .tap_axis_order,
  .tap_threshold_axis_x, .tap_threshold_axis_y, .tap_threshold_axis_z, .accel_low_power,
  .gyro_sleep, .gyro_power_down, .event_int1, .irq);
`default_nettype wire

// [testbench/tb.sv]
`include "tapcfg_regs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        odr_tick = 1'b0, sleep_state = 1'b0;
  logic        pin1_sleep_change_route = 1'b0, pin2_sleep_change_route = 1'b0;
  logic [4:0]  event_raw = 5'h00, tap_threshold_axis_x, tap_threshold_axis_y;
  logic [15:0] accel_slope = 16'h1234, accel_highpass = 16'habcd, wake_filter_data;
  logic [4:0]  tap_threshold_axis_z;
  logic [2:0]  tap_axis_enable;
  logic [8:0]  tap_axis_order;
  logic        accel_low_power, gyro_sleep, gyro_power_down, event_int1, event_int2, irq;
  int          n_errors = 0;
  int          checks = 0;
  // axis order {max,mid,min} per priority code, one-hot x=001 y=010 z=100
  logic [8:0]  order_exp [8] = '{9'h054, 9'h08c, 9'h062, 9'h111,
                                 9'h054, 9'h0a1, 9'h10a, 9'h111};
  tapcfg_core i_dut (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .odr_tick, .event_raw, .sleep_state, .accel_slope, .accel_highpass,
    .pin1_sleep_change_route, .pin2_sleep_change_route, .wake_filter_data,
    .tap_axis_enable, .tap_axis_order, .tap_threshold_axis_x, .tap_threshold_axis_y,
    .tap_threshold_axis_z, .accel_low_power, .gyro_sleep, .gyro_power_down,
    .event_int1, .event_int2, .irq);
  // 125 MHz clock
  always #4 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // one-cycle tap event or end-of-period tick
  task automatic pulse(input logic ev);
    @(posedge clock);
    if (ev) event_raw <= 5'h08;
    else odr_tick <= 1'b1;
    @(posedge clock);
    event_raw <= 5'h00;
    odr_tick <= 1'b0;
    settle;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    #100_000;
    n_errors++;
    conclude;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    for (int a = 8'h56; a < 8'h5a; a++) rd(a[7:0], 8'h00);
    rd(8'h10, 8'h00);
    chk(wake_filter_data, 16'h1234);
    wr(`TAPCFG_OFS_CFG0, 8'h10);
    settle;
    chk(wake_filter_data, 16'habcd);
    for (int i = 0; i < 3; i++) begin
      wr(`TAPCFG_OFS_CFG0, 8'h02 << i);
      settle;
      chk(tap_axis_enable, 3'b001 << i);
    end
    for (int i = 0; i < 8; i++) begin
      wr(`TAPCFG_OFS_CFG1, {i[2:0], 5'h11});
      settle;
      chk(tap_axis_order, order_exp[i]);
      rd(`TAPCFG_OFS_CFG1, {i[2:0], 5'h11});
    end
    for (int i = 0; i < 4; i++) begin
      wr(`TAPCFG_OFS_CFG2, {1'b0, i[1:0], 5'h0a});
      settle;
      chk({accel_low_power, gyro_sleep, gyro_power_down}, {i != 0, i == 2, i == 3});
    end
    wr(`TAPCFG_OFS_CFG1, 8'h15);
    wr(`TAPCFG_OFS_THSZ, 8'h1f);
    settle;
    chk({tap_threshold_axis_x, tap_threshold_axis_y, tap_threshold_axis_z}, 15'h555f);
    // unlatched events follow the condition; masked status stays quiet
    wr(`TAPCFG_OFS_CFG0, 8'h00);
    wr(`TAPCFG_OFS_CFG2, 8'h80);
    event_raw <= 5'h04;
    settle;
    chk({event_int2, irq}, 2'b10);
    @(posedge clock);
    event_raw <= 5'h00;
    settle;
    chk(event_int2, 1'b0);
    rd(`TAPCFG_OFS_STATUS, 8'h04);
    // latched with clear on status read
    wr(`TAPCFG_OFS_MASK, 8'h08);
    wr(`TAPCFG_OFS_CFG0, 8'h41);
    pulse(1'b1);
    chk({event_int1, irq}, 2'b11);
    pulse(1'b0);
    chk(event_int1, 1'b1);
    rd(`TAPCFG_OFS_STATUS, 8'h08);
    settle;
    chk({event_int1, irq}, 2'b00);
    // latched, cleared by the period tick
    wr(`TAPCFG_OFS_CFG0, 8'h01);
    pulse(1'b1);
    chk(event_int1, 1'b1);
    pulse(1'b0);
    chk({event_int1, irq}, 2'b01);
    rd(`TAPCFG_OFS_STATUS, 8'h08);
    // global enable off, then sleep level on pin 1
    wr(`TAPCFG_OFS_CFG2, 8'h00);
    event_raw <= 5'h1f;
    settle;
    chk(event_int1, 1'b0);
    @(posedge clock);
    event_raw <= 5'h00;
    wr(`TAPCFG_OFS_CFG0, 8'h20);
    pin1_sleep_change_route <= 1'b1;
    sleep_state <= 1'b1;
    settle;
    chk({event_int1, event_int2}, 2'b10);
    wr(`TAPCFG_OFS_CFG0, 8'h00);
    settle;
    chk(event_int1, 1'b0);
    // sleep change notification: one-cycle pulse on both routed pins
    @(posedge clock);
    sleep_state <= 1'b0;
    pin2_sleep_change_route <= 1'b1;
    @(posedge clock);
    #1 chk({event_int1, event_int2}, 2'b11);
    settle;
    chk({event_int1, event_int2}, 2'b00);
    conclude;
  end
endmodule
`default_nettype wire
